// ===== logic/bcs_pkg.sv
/*
 package of the charge sequencer: timing counts, voltage and temperature
 codes, phase encoding and carrier structs.
 assumes a 50 MHz system clock and 10-bit codes from an external adc.
*/
package bcs_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned WAKE_MIN = 60;
  localparam int unsigned DONE_MIN = 2;
  localparam int unsigned PULSE_MIN_MS = 100;
  localparam int unsigned PULSE_MAX_MS = 1000;
  localparam int unsigned PULSE_STEP_MS = 100;
  localparam int unsigned PERIOD_MS = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam longint unsigned WAKE_CYC =
    longint'(WAKE_MIN) * 60 * CLK_HZ;
  localparam longint unsigned DONE_CYC =
    longint'(DONE_MIN) * 60 * CLK_HZ;
  localparam int CW = 38;
  localparam int MW = 16;
  localparam logic [9:0] VBAT_WAKE_MV10 = 10'h140;
  localparam logic [9:0] VBAT_IGN_MV10 = 10'h12C;
  localparam logic [9:0] VBAT_FULL_MV10 = 10'h1A4;
  localparam logic signed [7:0] TEMP_LO_C = 8'sh00;
  localparam logic signed [7:0] TEMP_HI_C = 8'sh2D;

  typedef enum logic [5:0] {
    PH_IDLE    = 6'h01,
    PH_TRICKLE = 6'h02,
    PH_CC      = 6'h04,
    PH_PULSE   = 6'h08,
    PH_DONE    = 6'h10,
    PH_TIMEOUT = 6'h20
  } bcs_phase_type;

  typedef struct packed {
    logic charger_present;
    logic ntc_present;
    logic undervoltage;
    logic ignition_n;
    logic [9:0] vbat_mv10;
    logic signed [7:0] temp_c;
  } bcs_sense_type;

  typedef struct packed {
    logic trickle_en;
    logic fast_en;
    logic power_on;
    logic cpu_wake;
  } bcs_drive_type;
endpackage

// ===== logic/bcs_seq.sv
/*
 charge sequencer: trickle, wake timer, constant current and pulsed
 fast charge, completion, ignition recovery and undervoltage handling.
 assumes sense inputs are asynchronous levels; voltage in 10 mV units,
 temperature in degrees c, both held stable by the adc between samples.
*/
`timescale 1ns/10ps
// Behaviour
// - charger detected starts charge in trickle
// - trickle source alone limits current below 10mA
// - 3.2V before 60min timer wakes processor
// - fast charge runs alongside trickle
// - constant current to 4.2V, then pulses
// - shrink duty to avoid 4.2V overshoot
// - done at 100ms pulse, duty steady 2min
// - charge only between 0 and 45 C
// - no thermistor, no charge start
// - undervoltage powers down, restarts trickle
// - timer expiry blocks processor charging
// - ignition low at >=3V after expiry starts fast
// - ignition low below 3V stops timer
// - charger reconnect restarts whole sequence
// - trickle on whenever charger present; code also needs the thermistor and the 0 to 45 C window
module bcs_seq #(
  parameter longint unsigned WAKE_CYCLES = bcs_pkg::WAKE_CYC,
  parameter longint unsigned DONE_CYCLES = bcs_pkg::DONE_CYC,
  parameter int unsigned MS_CYCLES = bcs_pkg::CYC_PER_MS
) (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire bcs_pkg::bcs_sense_type sense_i,
  output bcs_pkg::bcs_drive_type drive_o,
  output bcs_pkg::bcs_phase_type phase_o,
  output logic [15:0] pulse_ms_o,
  output logic phase_evt_o
);
  bcs_pkg::bcs_sense_type s1_ff;
  bcs_pkg::bcs_sense_type s2_ff;
  bcs_pkg::bcs_phase_type st_ff, nxt_st;
  logic [bcs_pkg::CW-1:0] tmr_ff, nxt_tmr;
  logic tmr_run_ff, nxt_tmr_run;
  logic [bcs_pkg::MW-1:0] ms_ff, nxt_ms;
  logic [15:0] msc_ff, nxt_msc;
  logic [15:0] width_ff, nxt_width;
  logic pulse_on_ff, nxt_pulse_on;
  logic [bcs_pkg::CW-1:0] steady_ff, nxt_steady;
  logic chg_d_ff;
  logic evt_ff, nxt_evt;
  logic ign_lock_ff, nxt_ign_lock;
  logic temp_ok;
  logic ms_tick;

  function automatic logic at_least(input logic [9:0] v,
                                    input logic [9:0] lim);
    at_least = (v >= lim);
  endfunction

  function automatic bcs_pkg::bcs_phase_type bcs_bhold(
    input bcs_pkg::bcs_sense_type s);
    bcs_bhold = s.ntc_present ? bcs_pkg::PH_TRICKLE : bcs_pkg::PH_IDLE;
  endfunction

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
    end
    else
    begin
      s1_ff <= sense_i;
      s2_ff <= s1_ff;
    end
  end

  assign temp_ok = (s2_ff.temp_c >= bcs_pkg::TEMP_LO_C) &&
                   (s2_ff.temp_c <= bcs_pkg::TEMP_HI_C);
  assign ms_tick = (ms_ff == bcs_pkg::MW'(MS_CYCLES - 1));

  always_comb
  begin
    nxt_st = st_ff;
    nxt_tmr = tmr_ff;
    nxt_tmr_run = tmr_run_ff;
    nxt_ms = ms_tick ? '0 : ms_ff + 1'b1;
    nxt_msc = msc_ff;
    nxt_width = width_ff;
    nxt_pulse_on = pulse_on_ff;
    nxt_steady = steady_ff;
    nxt_ign_lock = ign_lock_ff;
    if (tmr_run_ff)
      nxt_tmr = tmr_ff + 1'b1;
    if (!s2_ff.charger_present || s2_ff.undervoltage)
    begin
      // undervoltage restarts trickle, unplug goes idle
      nxt_st = s2_ff.charger_present ? bcs_bhold(s2_ff)
                                     : bcs_pkg::PH_IDLE;
      nxt_tmr = '0;
      nxt_tmr_run = s2_ff.charger_present && s2_ff.ntc_present;
      nxt_ign_lock = 1'b0;
    end
    else if (s2_ff.charger_present && !chg_d_ff)
    begin
      nxt_tmr = '0;
      nxt_ign_lock = 1'b0;
      nxt_tmr_run = s2_ff.ntc_present;
      nxt_st = s2_ff.ntc_present ? bcs_pkg::PH_TRICKLE
                                 : bcs_pkg::PH_IDLE;
    end
    else
    begin
      case (st_ff)
        bcs_pkg::PH_IDLE:
        begin
          nxt_tmr_run = 1'b0;
        end
        bcs_pkg::PH_TRICKLE:
        begin
          if (at_least(s2_ff.vbat_mv10, bcs_pkg::VBAT_WAKE_MV10)
              && temp_ok)
          begin
            nxt_st = bcs_pkg::PH_CC;
            nxt_tmr_run = 1'b0;
          end
          else if (tmr_run_ff && tmr_ff >= bcs_pkg::CW'(WAKE_CYCLES - 1))
          begin
            nxt_st = bcs_pkg::PH_TIMEOUT;
            nxt_tmr_run = 1'b0;
          end
        end
        bcs_pkg::PH_TIMEOUT:
        begin
          if (!s2_ff.ignition_n)
          begin
            if (at_least(s2_ff.vbat_mv10, bcs_pkg::VBAT_IGN_MV10))
            begin
              if (!ign_lock_ff)
                nxt_st = bcs_pkg::PH_CC;
            end
            else
            begin
              nxt_tmr_run = 1'b0;
              nxt_ign_lock = 1'b1;
            end
          end
        end
        bcs_pkg::PH_CC:
        begin
          if (at_least(s2_ff.vbat_mv10, bcs_pkg::VBAT_FULL_MV10))
          begin
            nxt_st = bcs_pkg::PH_PULSE;
            nxt_width = 16'(bcs_pkg::PULSE_MAX_MS);
            nxt_msc = '0;
            nxt_pulse_on = 1'b1;
            nxt_steady = '0;
          end
        end
        bcs_pkg::PH_PULSE:
        begin
          nxt_steady = steady_ff + 1'b1;
          if (ms_tick)
          begin
            nxt_msc = (msc_ff == 16'(bcs_pkg::PERIOD_MS - 1)) ? '0
                      : msc_ff + 1'b1;
            nxt_pulse_on = (nxt_msc < width_ff);
          end
          if (pulse_on_ff && s2_ff.vbat_mv10 > bcs_pkg::VBAT_FULL_MV10
              && width_ff > 16'(bcs_pkg::PULSE_MIN_MS) && ms_tick)
          begin
            nxt_width = width_ff - 16'(bcs_pkg::PULSE_STEP_MS);
            nxt_steady = '0;
          end
          if (width_ff == 16'(bcs_pkg::PULSE_MIN_MS) &&
              steady_ff >= bcs_pkg::CW'(DONE_CYCLES - 1))
            nxt_st = bcs_pkg::PH_DONE;
        end
        bcs_pkg::PH_DONE:
        begin
          nxt_tmr_run = 1'b0;
        end
        default:
        begin
          nxt_st = bcs_pkg::PH_IDLE;
        end
      endcase
    end
  end

  assign nxt_evt = (nxt_st != st_ff);

  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= bcs_pkg::PH_IDLE;
      tmr_ff <= '0;
      tmr_run_ff <= 1'b0;
      ms_ff <= '0;
      msc_ff <= '0;
      width_ff <= '0;
      pulse_on_ff <= 1'b0;
      steady_ff <= '0;
      chg_d_ff <= 1'b0;
      evt_ff <= 1'b0;
      ign_lock_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      tmr_run_ff <= nxt_tmr_run;
      ms_ff <= nxt_ms;
      msc_ff <= nxt_msc;
      width_ff <= nxt_width;
      pulse_on_ff <= nxt_pulse_on;
      steady_ff <= nxt_steady;
      chg_d_ff <= s2_ff.charger_present;
      evt_ff <= nxt_evt;
      ign_lock_ff <= nxt_ign_lock;
    end
  end

  // fast charge enabled only in cc or on-part of pulse, in temp window
  always_comb
  begin
    drive_o.trickle_en = s2_ff.charger_present && temp_ok
                         && s2_ff.ntc_present;
    drive_o.fast_en = temp_ok && ((st_ff == bcs_pkg::PH_CC) ||
                      (st_ff == bcs_pkg::PH_PULSE && pulse_on_ff));
    drive_o.power_on = (st_ff == bcs_pkg::PH_CC) ||
                       (st_ff == bcs_pkg::PH_PULSE) ||
                       (st_ff == bcs_pkg::PH_DONE);
    drive_o.cpu_wake = drive_o.power_on;
  end

  assign phase_o = st_ff;
  assign pulse_ms_o = width_ff;
  assign phase_evt_o = evt_ff;

  phase_onehot_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) $onehot(st_ff))
    else $error("phase not one-hot");
  trickle_follow_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    drive_o.trickle_en |-> s2_ff.charger_present && temp_ok)
    else $error("trickle without charger");
  trickle_on_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    s2_ff.charger_present && s2_ff.ntc_present && temp_ok
    |-> drive_o.trickle_en)
    else $error("trickle missing with charger");
  no_ntc_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    !s2_ff.ntc_present && s2_ff.charger_present && !chg_d_ff
    |=> st_ff == bcs_pkg::PH_IDLE)
    else $error("charge started without thermistor");
  start_trickle_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    s2_ff.ntc_present && s2_ff.charger_present && !chg_d_ff
    && !s2_ff.undervoltage
    |=> st_ff == bcs_pkg::PH_TRICKLE && tmr_ff == '0 && tmr_run_ff)
    else $error("charge did not open in trickle");
  temp_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) !temp_ok |-> !drive_o.fast_en)
    else $error("fast charge outside temperature window");
  wake_power_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_CC && temp_ok
    |-> drive_o.power_on && drive_o.cpu_wake && drive_o.fast_en)
    else $error("constant current without processor power");
  pulse_entry_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_CC && s2_ff.charger_present && chg_d_ff
    && !s2_ff.undervoltage
    && at_least(s2_ff.vbat_mv10, bcs_pkg::VBAT_FULL_MV10)
    |=> st_ff == bcs_pkg::PH_PULSE
    && width_ff == 16'(bcs_pkg::PULSE_MAX_MS))
    else $error("full voltage did not start pulses");
  width_step_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_PULSE && $past(st_ff) == bcs_pkg::PH_PULSE
    && width_ff != $past(width_ff)
    |-> width_ff == $past(width_ff) - 16'(bcs_pkg::PULSE_STEP_MS))
    else $error("pulse width step wrong");
  width_floor_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_PULSE |-> width_ff >= 16'(bcs_pkg::PULSE_MIN_MS))
    else $error("pulse width below floor");
  done_gate_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_DONE && $past(st_ff) == bcs_pkg::PH_PULSE
    |-> width_ff == 16'(bcs_pkg::PULSE_MIN_MS)
    && $past(steady_ff) >= bcs_pkg::CW'(DONE_CYCLES - 1))
    else $error("charge done too early");
  timeout_dark_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_TIMEOUT |-> !drive_o.cpu_wake && !drive_o.fast_en)
    else $error("processor charging after timer expiry");
  ign_start_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_TIMEOUT && !s2_ff.ignition_n && !ign_lock_ff
    && s2_ff.charger_present && chg_d_ff && !s2_ff.undervoltage
    && at_least(s2_ff.vbat_mv10, bcs_pkg::VBAT_IGN_MV10)
    |=> st_ff == bcs_pkg::PH_CC)
    else $error("ignition at 3V did not start charging");
  ign_low_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i)
    st_ff == bcs_pkg::PH_TIMEOUT && !s2_ff.ignition_n && s2_ff.charger_present
    && !s2_ff.undervoltage && chg_d_ff
    && s2_ff.vbat_mv10 < bcs_pkg::VBAT_IGN_MV10
    |=> st_ff == bcs_pkg::PH_TIMEOUT && !tmr_run_ff && ign_lock_ff)
    else $error("ignition below 3V left timeout");
  ign_lock_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) ign_lock_ff |=> st_ff != bcs_pkg::PH_CC)
    else $error("locked timeout reached constant current");
  uv_power_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) s2_ff.undervoltage |=> !drive_o.power_on)
    else $error("undervoltage did not power down");
  phase_evt_a: assert property (@(posedge clk_sys_i)
    disable iff (!nrst_i) st_ff != $past(st_ff) |-> phase_evt_o)
    else $error("phase change without event");

  cov_wake_c: cover property (@(posedge clk_sys_i)
    st_ff == bcs_pkg::PH_TRICKLE ##1 st_ff == bcs_pkg::PH_CC);
  cov_timeout_c: cover property (@(posedge clk_sys_i)
    st_ff == bcs_pkg::PH_TIMEOUT ##1 st_ff == bcs_pkg::PH_CC);
  cov_done_c: cover property (@(posedge clk_sys_i)
    st_ff == bcs_pkg::PH_DONE);
  cov_lock_c: cover property (@(posedge clk_sys_i)
    st_ff == bcs_pkg::PH_TIMEOUT && ign_lock_ff);
  cov_uv_c: cover property (@(posedge clk_sys_i)
    st_ff == bcs_pkg::PH_DONE ##1 st_ff == bcs_pkg::PH_TRICKLE);
endmodule

// ===== test/bcs_pack_model.sv
/*
 battery pack and charger model: packs bench levels into sense struct,
 fast current lifts the battery voltage by an overshoot amount.
 assumes levels come from the bench, drive from the sequencer.
*/
`timescale 1ns/10ps
module bcs_pack_model (
  input wire logic chg_i,
  input wire logic ntc_i,
  input wire logic uv_i,
  input wire logic ign_n_i,
  input wire logic [9:0] vbat_i,
  input wire logic [9:0] bump_i,
  input wire logic signed [7:0] temp_i,
  input wire bcs_pkg::bcs_drive_type drive_i,
  output bcs_pkg::bcs_sense_type sense_o
);
  always_comb
  begin
    sense_o.charger_present = chg_i;
    sense_o.ntc_present = ntc_i;
    sense_o.undervoltage = uv_i;
    sense_o.ignition_n = ign_n_i;
    sense_o.vbat_mv10 = vbat_i + (drive_i.fast_en ? bump_i : 10'h000);
    sense_o.temp_c = temp_i;
  end
endmodule

// ===== test/tb.sv
/*
 self-checking bench of the charge sequencer with pack model.
 assumes shortened counts: wake 200, done 50, 4 cycles per ms.
*/
`timescale 1ns/10ps
module tb;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic chg = 1'b0;
  logic ntc = 1'b0;
  logic uv = 1'b0;
  logic ign_n = 1'b1;
  logic [9:0] vbat = 10'h0FA;
  logic [9:0] bump = 10'h000;
  logic signed [7:0] temp = 8'sh19;
  logic signed [7:0] tc [4] = '{8'sh00, 8'sh2D, -8'sh01, 8'sh2E};
  bcs_pkg::bcs_sense_type sense;
  bcs_pkg::bcs_drive_type drive;
  bcs_pkg::bcs_phase_type phase;
  logic [15:0] pulse_ms;
  logic evt;
  int mismatches = 0;
  int num_checks = 0;
  int evts = 0;
  int e0 = 0;
  logic [31:0] rng = 32'h19D1E914;
  always #10 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) if (evt === 1'b1) evts++;
  bcs_pack_model i_bcs_pack_model (.chg_i(chg), .ntc_i(ntc), .uv_i(uv),
    .ign_n_i(ign_n), .vbat_i(vbat), .bump_i(bump), .temp_i(temp),
    .drive_i(drive), .sense_o(sense));
  bcs_seq #(.WAKE_CYCLES(200), .DONE_CYCLES(50), .MS_CYCLES(4)) i_bcs_seq (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .sense_i(sense),
    .drive_o(drive), .phase_o(phase), .pulse_ms_o(pulse_ms),
    .phase_evt_o(evt));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic exp_trk(input logic signed [7:0] t);
    return (t >= bcs_pkg::TEMP_LO_C) && (t <= bcs_pkg::TEMP_HI_C);
  endfunction
  task automatic final_report;
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_ph(input bcs_pkg::bcs_phase_type exp);
    num_checks++;
    if (phase !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, phase, exp);
    end
  endtask
  task automatic wait_ph(input bcs_pkg::bcs_phase_type exp, input int m);
    for (int k = 0; k < m && phase !== exp; k++) step(1);
    chk_ph(exp);
  endtask
  initial
  begin
    step(4);
    nrst_i = 1'b1;
    step(2);
    chg = 1'b1;
    step(6);
    chk_ph(bcs_pkg::PH_IDLE);
    chk_v(16'(drive.trickle_en), 16'h0000);
    chg = 1'b0;
    ntc = 1'b1;
    step(4);
    e0 = evts;
    chg = 1'b1;
    step(5);
    chk_ph(bcs_pkg::PH_TRICKLE);
    chk_v(16'(evts - e0), 16'h0001);
    for (int i = 0; i < 16; i++)
    begin
      rng = xs(rng);
      temp = (i < 4) ? tc[i] : 8'(rng % 32'd70) - 8'sd20;
      step(4);
      chk_v(16'(drive.trickle_en), 16'(exp_trk(temp)));
    end
    temp = 8'sh19;
    vbat = 10'h14A;
    wait_ph(bcs_pkg::PH_CC, 10);
    chk_v(16'({drive.cpu_wake, drive.power_on}), 16'h0003);
    chk_v(16'({drive.fast_en, drive.trickle_en}), 16'h0003);
    temp = 8'sh32;
    step(4);
    chk_v(16'({drive.fast_en, drive.trickle_en}), 16'h0000);
    temp = 8'sh19;
    vbat = 10'h1A4;
    wait_ph(bcs_pkg::PH_PULSE, 10);
    chk_v(pulse_ms, 16'h03E8);
    bump = 10'h005;
    for (int k = 0; k < 100 && pulse_ms !== 16'h0064; k++) step(1);
    chk_v(pulse_ms, 16'h0064);
    step(20);
    chk_ph(bcs_pkg::PH_PULSE);
    wait_ph(bcs_pkg::PH_DONE, 60);
    uv = 1'b1;
    wait_ph(bcs_pkg::PH_TRICKLE, 10);
    chk_v(16'(drive.power_on), 16'h0000);
    uv = 1'b0;
    bump = 10'h000;
    vbat = 10'h0FA;
    wait_ph(bcs_pkg::PH_TIMEOUT, 260);
    chk_v(16'(drive.cpu_wake), 16'h0000);
    vbat = 10'h122;
    ign_n = 1'b0;
    step(6);
    ign_n = 1'b1;
    vbat = 10'h136;
    step(6);
    ign_n = 1'b0;
    step(6);
    chk_ph(bcs_pkg::PH_TIMEOUT);
    ign_n = 1'b1;
    chg = 1'b0;
    step(4);
    chk_ph(bcs_pkg::PH_IDLE);
    vbat = 10'h0FA;
    chg = 1'b1;
    step(5);
    chk_ph(bcs_pkg::PH_TRICKLE);
    wait_ph(bcs_pkg::PH_TIMEOUT, 260);
    vbat = 10'h131;
    ign_n = 1'b0;
    wait_ph(bcs_pkg::PH_CC, 10);
    ign_n = 1'b1;
    final_report();
  end
  initial
  begin
    #(20 * 5000);
    mismatches++;
    final_report();
  end
endmodule
